// *** hw/wcd_decoder.sv ***
/*
 * Serial command decoder for a 10-bit wiper and a 16-word nonvolatile store.
 * Assumes the serial clock is far slower than I_CLK (edges found by sampling),
 * and that the host drives 24-bit frames, MSB first, framed by chip select.
 */
// Function
// [RQ1] Code 0 does nothing, leaves read power
// [RQ2] Code 1 restores wiper, enters read power
// [RQ3] Code 2 stores wiper into word 0
// [RQ4] Code 3 writes 16 data bits to word
// [RQ5] Word 0 keeps only low ten bits; code 3 stores all 16 data bits there, the wiper reads the low ten
// [RQ6] Codes 4,5 halve the wiper
// [RQ7] Codes 6,7 step the wiper down
// [RQ8] Code 8 reloads wiper from word 0
// [RQ9] Code 9 queues stored word for readback
// [RQ10] Code 10 queues wiper for readback
// [RQ11] Code 11 loads wiper from data bits
// [RQ12] Codes 12,13 double the wiper
// [RQ13] Codes 14,15 step the wiper up
// [RQ14] Serial output echoes input delayed 24 bits
// [RQ15] Readback data replaces echoed data bytes
// [RQ16] Host sends full frame after readback
// [RQ17] Wiper loads from word 0 at power-on
// [RQ18] Commands execute only on chip select rise
// [RQ19] Step commands ignore the data bytes
// [RQ20] Frame: command, address, data, MSB first
// [RQ21] Doubling saturates; zero becomes one
// [RQ22] Write protect freezes wiper except restores
// [RQ23] Single steps saturate at both ends
module wcd_decoder (
    // System clock and power-on reset
    input  wire logic       I_CLK,
    input  wire logic       I_SYS_RST,
    // Serial link pins
    input  wire logic       I_SCLK,
    input  wire logic       I_CS_N,
    input  wire logic       I_SDI,
    // Protection and preset pins
    input  wire logic       I_WP_N,
    input  wire logic       I_PRESET_STROBE_N,
    // Open-drain serial output
    output logic            O_SDO,
    output logic            O_SDO_OE,
    // Wiper and power state
    output logic [9:0]      O_WIPER,
    output logic            O_READ_PWR
);

    logic [4:0]               pins_s;       // Synchronised pins
    logic                     sclk_s;       // Synchronised serial clock
    logic                     sdi_s;        // Synchronised serial data
    logic                     cs_n_s;       // Synchronised chip select
    logic                     wp_n_s;       // Synchronised write protect
    logic                     pr_n_s;       // Synchronised preset strobe
    logic                     sclk_d_q;     // Serial clock one cycle back
    logic                     sclk_rise;    // Sampling edge
    logic                     sclk_fall;    // Output edge
    wcd_pkg::wcd_state_t      state_q;      // Decoder state
    wcd_pkg::wcd_state_t      state_d;
    logic [23:0]              sr_q;         // Serial shift register
    logic [4:0]               cnt_q;        // Bit count modulo one frame
    logic                     got_q;        // Any bit seen this frame
    logic [23:0]              last_q;       // Last executed frame
    logic                     have_last_q;  // A frame has executed since reset
    logic [23:0]              word;         // Frame to execute
    logic [3:0]               cmd;
    logic [3:0]               addr;
    logic [15:0]              data;
    logic                     addr0;        // Address field is zero
    logic                     cs_rise;      // End of frame
    logic                     exec;         // Execute strobe
    logic                     step_ok;      // Step command allowed
    logic [9:0]               wiper_q;
    logic [9:0]               wiper_d;
    // Nonvolatile store; the power-up image stands in for retained contents, never reset
    logic [15:0]              nv_q [wcd_pkg::NV_WORDS] = '{
        wcd_pkg::ADDR_WIPER: wcd_pkg::NV_WORD0_INIT,
        default:             wcd_pkg::NV_USER_INIT
    };
    logic [9:0]               nv0_wiper;    // Wiper part of word 0
    logic                     read_pwr_q;
    logic                     sdo_q;
    logic                     sdo_oe_q;

    // All pins cross into the system clock before any use
    wcd_sync #(
        .W       (5),
        .RST_VAL (wcd_pkg::PIN_RST)
    ) u_sync (
        .i_clk (I_CLK),
        .i_rst (I_SYS_RST),
        .i_d   ({I_PRESET_STROBE_N, I_WP_N, I_CS_N, I_SDI, I_SCLK}),
        .o_q   (pins_s)
    );

    assign sclk_s = pins_s[0];
    assign sdi_s  = pins_s[1];
    assign cs_n_s = pins_s[2];
    assign wp_n_s = pins_s[3];
    assign pr_n_s = pins_s[4];

    // Edge detection on the synchronised serial clock
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            sclk_d_q <= 1'b0;
        end else begin
            sclk_d_q <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_q;
    assign sclk_fall = ~sclk_s & sclk_d_q;

    // State sequencing; refresh runs once after reset
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            wcd_pkg::ST_REFRESH: state_d = wcd_pkg::ST_IDLE;
            wcd_pkg::ST_IDLE:    if (!cs_n_s) state_d = wcd_pkg::ST_FRAME;
            wcd_pkg::ST_FRAME:   if (cs_n_s) state_d = wcd_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            state_q <= wcd_pkg::ST_REFRESH;
        end else begin
            state_q <= state_d;
        end
    end

    // A pulse of chip select with no bits repeats the previous frame
    assign cs_rise = (state_q == wcd_pkg::ST_FRAME) && cs_n_s;
    assign exec    = cs_rise && (got_q ? (cnt_q == '0) : have_last_q);  // RQ18
    assign word    = got_q ? sr_q : last_q;
    assign cmd     = word[wcd_pkg::CMD_MSB:wcd_pkg::CMD_LSB];      // RQ20
    assign addr    = word[wcd_pkg::ADDR_MSB:wcd_pkg::ADDR_LSB];    // RQ20
    assign data    = word[wcd_pkg::DATA_MSB:0];                    // RQ20
    assign addr0   = (addr == wcd_pkg::ADDR_WIPER);
    // Odd step codes skip the address check; data bytes never matter
    assign step_ok = wp_n_s && (addr0 || cmd[0]);                  // RQ19
    assign nv0_wiper = nv_q[wcd_pkg::ADDR_WIPER][wcd_pkg::WIPER_W-1:0];  // RQ5

    // Shift in on the rising edge; readback overwrites the data bytes
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            sr_q  <= '0;
            cnt_q <= '0;
            got_q <= 1'b0;
        end else if (state_q == wcd_pkg::ST_IDLE && !cs_n_s) begin
            // Partial counts never carry into a new frame
            cnt_q <= '0;
            got_q <= 1'b0;
        end else if (state_q == wcd_pkg::ST_FRAME && !cs_n_s && sclk_rise) begin
            sr_q  <= {sr_q[wcd_pkg::FRAME_BITS-2:0], sdi_s};        // RQ14
            cnt_q <= (cnt_q == wcd_pkg::FRAME_LAST) ? 5'h00 : cnt_q + 5'h01;
            got_q <= 1'b1;
        end else if (exec && cmd == wcd_pkg::CMD_RD_NV) begin
            sr_q[wcd_pkg::DATA_MSB:0] <= nv_q[addr];                // RQ9 RQ15
        end else if (exec && cmd == wcd_pkg::CMD_RD_WIPER && addr0) begin
            sr_q[wcd_pkg::DATA_MSB:0] <= {wcd_pkg::PAD_ZERO, wiper_q};  // RQ10 RQ15
        end
    end

    // Remember the executed frame for the chip-select repeat
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            last_q      <= '0;
            have_last_q <= 1'b0;
        end else if (exec) begin
            last_q      <= word;
            have_last_q <= 1'b1;
        end
    end

    // Doubling with the documented corner cases
    function automatic logic [9:0] up6(input logic [9:0] w);
        logic [9:0] r;
        r = {w[wcd_pkg::WIPER_W-2:0], 1'b0};
        if (w == wcd_pkg::WIPER_ZERO) r = wcd_pkg::WIPER_ONE;       // RQ21
        else if (w >= wcd_pkg::WIPER_MID) r = wcd_pkg::WIPER_FULL;  // RQ21
        return r;
    endfunction : up6

    // Next wiper value for the frame being executed
    always_comb begin
        wiper_d = wiper_q;
        unique case (cmd)
            wcd_pkg::CMD_RESTORE: begin
                // Restores pass even under write protect
                if (addr0) wiper_d = nv0_wiper;                     // RQ2 RQ22
            end
            wcd_pkg::CMD_RESET: begin
                wiper_d = nv0_wiper;                                // RQ8 RQ22
            end
            wcd_pkg::CMD_DN6_ADDR, wcd_pkg::CMD_DN6_ANY: begin
                if (step_ok) wiper_d = {1'b0, wiper_q[wcd_pkg::WIPER_W-1:1]};  // RQ6 RQ19
            end
            wcd_pkg::CMD_DEC_ADDR, wcd_pkg::CMD_DEC_ANY: begin
                // Holds at zero rather than wrapping
                if (step_ok && wiper_q != wcd_pkg::WIPER_ZERO) begin
                    wiper_d = wiper_q - wcd_pkg::WIPER_ONE;         // RQ7 RQ23
                end
            end
            wcd_pkg::CMD_UP6_ADDR, wcd_pkg::CMD_UP6_ANY: begin
                if (step_ok) wiper_d = up6(wiper_q);                // RQ12
            end
            wcd_pkg::CMD_INC_ADDR, wcd_pkg::CMD_INC_ANY: begin
                // Holds at full scale rather than wrapping
                if (step_ok && wiper_q != wcd_pkg::WIPER_FULL) begin
                    wiper_d = wiper_q + wcd_pkg::WIPER_ONE;         // RQ13 RQ23
                end
            end
            wcd_pkg::CMD_WR_WIPER: begin
                if (addr0 && wp_n_s) wiper_d = data[wcd_pkg::WIPER_W-1:0];  // RQ11 RQ22
            end
            default: begin
                // No-op, stores and reads leave the wiper alone
                wiper_d = wiper_q;                                  // RQ1
            end
        endcase
    end

    // Wiper register: refresh and preset beat any frame
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            wiper_q <= wcd_pkg::WIPER_ZERO;
        end else if (state_q == wcd_pkg::ST_REFRESH || !pr_n_s) begin
            wiper_q <= nv0_wiper;                                   // RQ17 RQ22
        end else if (exec) begin
            wiper_q <= wiper_d;                                     // RQ18
        end
    end

    // Store writes; protect also guards the store, as a hardware lock
    always_ff @(posedge I_CLK) begin
        if (exec && wp_n_s) begin
            if (cmd == wcd_pkg::CMD_STORE && addr0) begin
                nv_q[wcd_pkg::ADDR_WIPER] <= {wcd_pkg::PAD_ZERO, wiper_q};  // RQ3
            end else if (cmd == wcd_pkg::CMD_USER_WR) begin
                nv_q[addr] <= data;                                 // RQ4 RQ5
            end
        end
    end

    // Read power state: entered by restore, left by no-op
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            read_pwr_q <= 1'b0;
        end else if (exec && cmd == wcd_pkg::CMD_NOP) begin
            read_pwr_q <= 1'b0;                                     // RQ1
        end else if (exec && cmd == wcd_pkg::CMD_RESTORE && addr0) begin
            read_pwr_q <= 1'b1;                                     // RQ2
        end
    end

    // Serial output loads at select, then changes on each falling edge; pulls low only in a frame
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            sdo_q    <= 1'b1;
            sdo_oe_q <= 1'b0;
        end else if (cs_n_s) begin
            sdo_oe_q <= 1'b0;
        end else if (state_q == wcd_pkg::ST_IDLE || sclk_fall) begin
            sdo_q    <= sr_q[wcd_pkg::FRAME_BITS-1];                // RQ14
            sdo_oe_q <= ~sr_q[wcd_pkg::FRAME_BITS-1];
        end
    end

    assign O_SDO      = sdo_q;
    assign O_SDO_OE   = sdo_oe_q;
    assign O_WIPER    = wiper_q;
    assign O_READ_PWR = read_pwr_q;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    sequence s_inc_top;
        exec && (cmd == wcd_pkg::CMD_INC_ADDR || cmd == wcd_pkg::CMD_INC_ANY)
            && step_ok && pr_n_s && (wiper_q == wcd_pkg::WIPER_FULL);
    endsequence

    sequence s_dec_bottom;
        exec && (cmd == wcd_pkg::CMD_DEC_ADDR || cmd == wcd_pkg::CMD_DEC_ANY)
            && step_ok && pr_n_s && (wiper_q == wcd_pkg::WIPER_ZERO);
    endsequence

    sequence s_plain_exec;
        (state_q != wcd_pkg::ST_REFRESH) && pr_n_s;
    endsequence

    a_power_refresh: assert property ( // RQ17
        (state_q == wcd_pkg::ST_REFRESH) |=> (O_WIPER == $past(nv0_wiper)))
        else $error("wiper not refreshed from word 0");

    a_exec_only_cs: assert property ( // RQ18
        s_plain_exec ##1 (!exec && pr_n_s) |=> $stable(wiper_q))
        else $error("wiper changed without end of frame");

    a_inc_saturate: assert property ( // RQ23
        s_inc_top |=> (O_WIPER == wcd_pkg::WIPER_FULL))
        else $error("increment wrapped past full scale");

    a_dec_saturate: assert property ( // RQ23
        s_dec_bottom |=> (O_WIPER == wcd_pkg::WIPER_ZERO))
        else $error("decrement wrapped below zero");

    a_up6_fullscale: assert property ( // RQ21
        exec && (cmd == wcd_pkg::CMD_UP6_ANY) && wp_n_s && pr_n_s
            && (wiper_q >= wcd_pkg::WIPER_MID) |=> (O_WIPER == wcd_pkg::WIPER_FULL))
        else $error("doubling did not saturate");

    a_protect_write: assert property ( // RQ22
        exec && !wp_n_s && pr_n_s && (cmd == wcd_pkg::CMD_WR_WIPER) |=> $stable(O_WIPER))
        else $error("protected wiper was written");

    a_read_power: assert property ( // RQ2
        exec && (cmd == wcd_pkg::CMD_RESTORE) && addr0 |=> O_READ_PWR [*2])
        else $error("restore did not enter read power");

    a_nop_idle: assert property ( // RQ1
        exec && (cmd == wcd_pkg::CMD_NOP) |=> !O_READ_PWR)
        else $error("no-op left read power state set");

    a_readback_wiper: assert property ( // RQ10
        exec && (cmd == wcd_pkg::CMD_RD_WIPER) && addr0
            |=> (sr_q[9:0] == $past(wiper_q)))
        else $error("wiper not loaded for readback");

    a_sdo_released: assert property ( // RQ14
        cs_n_s |=> !O_SDO_OE)
        else $error("serial output driven outside a frame");

endmodule : wcd_decoder

// *** hw/wcd_sync.sv ***
/*
 * Two-flop synchroniser for a group of asynchronous pins.
 * Assumes the pins are quasi-static relative to the sampling clock.
 */
module wcd_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Pins in, synchronised levels out
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_q;    // First stage, read only by the second

    // Two stages; the first never feeds any logic directly
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= RST_VAL;
            o_q    <= RST_VAL;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end

endmodule : wcd_sync

// *** inc/wcd_pkg.sv ***
/*
 * Constants and types shared by the wiper command decoder.
 * Assumes one 20 MHz system clock; the serial pins are asynchronous to it.
 */
package wcd_pkg;

    // Frame layout
    localparam int          FRAME_BITS = 24;
    localparam logic [4:0]  FRAME_LAST = 5'h17;     // Index of the final bit of a frame
    localparam int          CMD_MSB    = 23;
    localparam int          CMD_LSB    = 20;
    localparam int          ADDR_MSB   = 19;
    localparam int          ADDR_LSB   = 16;
    localparam int          DATA_MSB   = 15;
    localparam int          WIPER_W    = 10;
    localparam int          DATA_W     = 16;
    localparam int          NV_WORDS   = 16;

    // Command codes
    localparam logic [3:0]  CMD_NOP       = 4'h0;
    localparam logic [3:0]  CMD_RESTORE   = 4'h1;
    localparam logic [3:0]  CMD_STORE     = 4'h2;
    localparam logic [3:0]  CMD_USER_WR   = 4'h3;
    localparam logic [3:0]  CMD_DN6_ADDR  = 4'h4;
    localparam logic [3:0]  CMD_DN6_ANY   = 4'h5;
    localparam logic [3:0]  CMD_DEC_ADDR  = 4'h6;
    localparam logic [3:0]  CMD_DEC_ANY   = 4'h7;
    localparam logic [3:0]  CMD_RESET     = 4'h8;
    localparam logic [3:0]  CMD_RD_NV     = 4'h9;
    localparam logic [3:0]  CMD_RD_WIPER  = 4'hA;
    localparam logic [3:0]  CMD_WR_WIPER  = 4'hB;
    localparam logic [3:0]  CMD_UP6_ADDR  = 4'hC;
    localparam logic [3:0]  CMD_UP6_ANY   = 4'hD;
    localparam logic [3:0]  CMD_INC_ADDR  = 4'hE;
    localparam logic [3:0]  CMD_INC_ANY   = 4'hF;

    // Addresses and wiper values
    localparam logic [3:0]  ADDR_WIPER = 4'h0;      // Nonvolatile word holding the wiper
    localparam logic [9:0]  WIPER_ZERO = 10'h000;
    localparam logic [9:0]  WIPER_ONE  = 10'h001;
    localparam logic [9:0]  WIPER_MID  = 10'h200;
    localparam logic [9:0]  WIPER_FULL = 10'h3FF;
    localparam logic [5:0]  PAD_ZERO   = 6'h00;

    // Power-up contents of the nonvolatile store
    localparam logic [15:0] NV_WORD0_INIT = 16'h0200;
    localparam logic [15:0] NV_USER_INIT  = 16'h0000;

    // Pin synchroniser reset: {preset_n, wp_n, cs_n, sdi, sclk}
    localparam logic [4:0]  PIN_RST = 5'h1C;

    // Decoder states
    typedef enum logic [2:0] {
        ST_REFRESH = 3'b001,
        ST_IDLE    = 3'b010,
        ST_FRAME   = 3'b100
    } wcd_state_t;

endpackage : wcd_pkg

// *** tb/wcd_host.sv ***
/*
 * Host model: serial bus master driving 24-bit frames into the decoder.
 * Assumes the bench's 20 MHz clock; serial clock of 400 ns, idle low (mode 0).
 */
module wcd_host (
    // Bench clock
    input  wire logic i_clk,
    // Serial pins toward the device
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_sdi,
    // Serial output wire level, after the pull-up
    input  wire logic i_sdo
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [23:0] rd;                        // Bits seen on the output wire

    // Idle levels; serial clock stands still between frames
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi  = 1'b0;
        rd     = 24'h000000;
    end

    // Data line toggles outside frames so a stale level never looks like data
    always @(posedge i_clk) begin
        if (o_cs_n) begin
            o_sdi <= ~o_sdi;
        end
    end

    // Select, then shift all bits MSB first; output sampled before each rise
    task automatic frame_bits(input logic [23:0] f);
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        repeat (8) @(posedge i_clk);
        for (int i = 23; i >= 0; i--) begin
            o_sdi <= f[i];
            repeat (5) @(posedge i_clk);
            rd[i] = i_sdo;
            o_sclk <= 1'b1;
            repeat (3) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
    endtask : frame_bits

    // Deselect and leave room for execution before the next frame
    task automatic frame_end;
        o_cs_n <= 1'b1;
        repeat (8) @(posedge i_clk);
    endtask : frame_end

    // Chip select pulse with no clocks; the device repeats its last frame
    task automatic cs_pulse;
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        repeat (8) @(posedge i_clk);
        frame_end();
    endtask : cs_pulse
endmodule : wcd_host

// *** tb/wiper_command_decoder_tb.sv ***
/*
 * Self-checking bench for the wiper command decoder, with its own reference model.
 * Assumes wcd_pkg is compiled first and the host model sits in wcd_host.
 */
module wiper_command_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        I_CLK;                     // 20 MHz system clock
    logic        I_SYS_RST;                 // Power-on refresh
    logic        I_WP_N;                    // Write protect, active low
    logic        I_PRESET_STROBE_N;         // Preset, active low
    logic        sclk, cs_n, serial_data_in;           // Host pins
    logic        O_SDO, O_SDO_OE, O_READ_PWR;
    logic [9:0]  O_WIPER;
    logic        sdo_w;                     // Open-drain wire with pull-up
    logic [9:0]  w;                         // Model wiper
    logic [15:0] nv [16];                   // Model store
    logic [15:0] rb;                        // Model readback value
    logic        rp, wp, rb_on, prev_rb, prev_ok;
    logic [23:0] prev;                      // Previous frame sent
    logic [25:0] exp_q [$];                 // Notes: kind and expected value
    logic [31:0] r;
    int          error_cnt, n_checks, cyc;
    event        note_e;

    assign sdo_w = O_SDO_OE ? O_SDO : 1'b1;

    wcd_decoder i_wcd_decoder (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_SCLK(sclk),
        .I_CS_N(cs_n), .I_SDI(serial_data_in), .I_WP_N(I_WP_N), .I_PRESET_STROBE_N(I_PRESET_STROBE_N),
        .O_SDO(O_SDO), .O_SDO_OE(O_SDO_OE), .O_WIPER(O_WIPER), .O_READ_PWR(O_READ_PWR));

    wcd_host i_wcd_host (.i_clk(I_CLK), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(serial_data_in),
        .i_sdo(sdo_w));

    // Clock
    initial begin
        I_CLK = 1'b0;
        forever #25 I_CLK = ~I_CLK;
    end

    // Hang guard; a full run needs roughly 17000 cycles
    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            stop_test();
        end
    end

    // Kind 0 wiper, 1 read power, 2 serial output word
    task automatic note(input logic [1:0] k, input logic [23:0] v);
        exp_q.push_back({k, v});
        -> note_e;
    endtask : note

    // Watcher drains every pending note against the outputs
    initial begin
        logic [25:0] n;
        logic [23:0] got;
        forever begin
            @(note_e);
            while (exp_q.size() > 0) begin
                n = exp_q.pop_front();
                case (n[25:24])
                    2'h0:    got = {14'h0000, O_WIPER};
                    2'h1:    got = {23'h0, O_READ_PWR};
                    default: got = i_wcd_host.rd;
                endcase
                n_checks++;
                if (got !== n[23:0]) begin
                    error_cnt++;
                    $display("unexpected at %0t: kind %0d got %h want %h",
                             $time, n[25:24], got, n[23:0]);
                end
            end
        end
    end

    // Reference behaviour of one executed frame; odd step codes skip the address
    task automatic apply(input logic [23:0] f);
        logic [3:0] c;
        logic       ok;
        c     = f[23:20];
        ok    = (f[19:16] == wcd_pkg::ADDR_WIPER) || (c[0] && c[2]);
        rb_on = 1'b0;
        case (c)
            wcd_pkg::CMD_NOP:     rp = 1'b0;
            wcd_pkg::CMD_RESTORE: if (ok) begin
                w  = nv[0][9:0];
                rp = 1'b1;
            end
            wcd_pkg::CMD_STORE:   if (ok && wp) nv[0] = {6'h00, w};
            wcd_pkg::CMD_USER_WR: if (wp) nv[f[19:16]] = f[15:0];
            wcd_pkg::CMD_DN6_ADDR, wcd_pkg::CMD_DN6_ANY: if (ok && wp) w = w >> 1;
            wcd_pkg::CMD_DEC_ADDR, wcd_pkg::CMD_DEC_ANY: if (ok && wp && w != 0) w = w - 1;
            wcd_pkg::CMD_RESET:   w = nv[0][9:0];
            wcd_pkg::CMD_RD_NV:   begin
                rb    = nv[f[19:16]];
                rb_on = 1'b1;
            end
            wcd_pkg::CMD_RD_WIPER: if (ok) begin
                rb    = {6'h00, w};
                rb_on = 1'b1;
            end
            wcd_pkg::CMD_WR_WIPER: if (ok && wp) w = f[9:0];
            wcd_pkg::CMD_UP6_ADDR, wcd_pkg::CMD_UP6_ANY: if (ok && wp) begin
                w = (w == 0) ? wcd_pkg::WIPER_ONE :
                    (w >= wcd_pkg::WIPER_MID) ? wcd_pkg::WIPER_FULL : w << 1;
            end
            default: if (ok && wp && w != wcd_pkg::WIPER_FULL) w = w + 1;
        endcase
    endtask : apply

    // One frame: wiper must hold while shifting, echo or readback on the wire
    task automatic send(input logic [23:0] f);
        i_wcd_host.frame_bits(f);
        note(2'h0, {14'h0000, w});
        if (prev_ok) note(2'h2, prev_rb ? {prev[23:16], rb} : prev);
        i_wcd_host.frame_end();
        apply(f);
        note(2'h0, {14'h0000, w});
        note(2'h1, {23'h0, rp});
        prev    = f;
        prev_rb = rb_on;
        prev_ok = 1'b1;
    endtask : send

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    // Main sequence
    initial begin
        I_SYS_RST = 1'b1;
        I_WP_N = 1'b1;
        I_PRESET_STROBE_N = 1'b1;
        {error_cnt, n_checks, cyc} = '0;
        {rp, rb_on, prev_rb, prev_ok} = 4'h0;
        {wp, w, rb, prev} = {1'b1, 10'h200, 16'h0000, 24'h000000};
        nv[0] = wcd_pkg::NV_WORD0_INIT;
        for (int i = 1; i < 16; i++) nv[i] = wcd_pkg::NV_USER_INIT;
        void'($urandom(70));
        repeat (2) @(posedge I_CLK);
        I_SYS_RST <= 1'b0;
        repeat (3) @(posedge I_CLK);
        note(2'h0, {14'h0000, w});
        r = $urandom;
        send({wcd_pkg::CMD_WR_WIPER, 4'h0, r[15:0]});
        send({wcd_pkg::CMD_WR_WIPER, 4'h0, 16'h0000});
        send({wcd_pkg::CMD_DEC_ANY, 4'h5, r[31:16]});
        for (int i = 0; i < 12; i++) send({wcd_pkg::CMD_UP6_ADDR, 4'h0, r[15:0]});
        send({wcd_pkg::CMD_UP6_ANY, 4'h9, r[15:0]});
        send({wcd_pkg::CMD_INC_ADDR, 4'h0, r[15:0]});
        send({wcd_pkg::CMD_DN6_ADDR, 4'h0, r[31:16]});
        send({wcd_pkg::CMD_DN6_ANY, 4'hA, r[15:0]});
        send({wcd_pkg::CMD_INC_ADDR, 4'h3, 16'h0000});
        send({wcd_pkg::CMD_DEC_ADDR, 4'h0, r[15:0]});
        // Bare chip select pulse repeats the decrement
        i_wcd_host.cs_pulse();
        apply(prev);
        note(2'h0, {14'h0000, w});
        send({wcd_pkg::CMD_STORE, 4'h0, 16'h0000});
        send({wcd_pkg::CMD_WR_WIPER, 4'h0, 16'h0123});
        send({wcd_pkg::CMD_RESET, 4'h7, r[15:0]});
        send({wcd_pkg::CMD_WR_WIPER, 4'h0, 16'h0321});
        send({wcd_pkg::CMD_RESTORE, 4'h0, 16'h0000});
        send({wcd_pkg::CMD_NOP, 4'h0, 16'h0000});
        send({wcd_pkg::CMD_USER_WR, 4'h5, r[31:16]});
        send({wcd_pkg::CMD_RD_NV, 4'h5, 16'h0000});
        send({wcd_pkg::CMD_RD_WIPER, 4'h0, 16'h0000});
        send({wcd_pkg::CMD_NOP, 4'h0, 16'h0000});
        send({wcd_pkg::CMD_USER_WR, 4'h0, r[15:0]});
        send({wcd_pkg::CMD_RESET, 4'h0, 16'h0000});
        I_WP_N <= 1'b0;
        wp = 1'b0;
        send({wcd_pkg::CMD_WR_WIPER, 4'h0, 16'h0055});
        send({wcd_pkg::CMD_INC_ANY, 4'h2, 16'h0000});
        send({wcd_pkg::CMD_USER_WR, 4'h5, 16'hBEEF});
        send({wcd_pkg::CMD_RD_NV, 4'h5, 16'h0000});
        send({wcd_pkg::CMD_RESTORE, 4'h0, 16'h0000});
        I_WP_N <= 1'b1;
        wp = 1'b1;
        send({wcd_pkg::CMD_WR_WIPER, 4'h0, 16'h02AA});
        I_PRESET_STROBE_N <= 1'b0;
        repeat (4) @(posedge I_CLK);
        I_PRESET_STROBE_N <= 1'b1;
        repeat (6) @(posedge I_CLK);
        w = nv[0][9:0];
        note(2'h0, {14'h0000, w});
        // Random traffic over every code; reads of word 0 avoided
        for (int i = 0; i < 40; i++) begin
            r = $urandom;
            if (r[23:20] == wcd_pkg::CMD_USER_WR || r[23:20] == wcd_pkg::CMD_RD_NV)
                r[19:16] = (r[19:16] == 4'h0) ? 4'h1 : r[19:16];
            else if (!(r[20] && r[22])) r[19:16] = 4'h0;
            send(r[23:0]);
        end
        repeat (2) @(posedge I_CLK);
        stop_test();
    end
endmodule : wiper_command_decoder_tb
